// ==== core/serial_attenuator_control.sv ====
// Purpose: serial control of a three-channel attenuator with cascade output
// Assumes: serial clock far slower than core_clk_in; reset is power-up
// Notes:   pin bit order to the synchroniser is {load_n, sclk, data}
//
// Notes on behaviour
// - selector byte 00, 01, 02 picks channel one, two, three.
// - codes map to 0.5, 1 and 2 dB steps; 4f and up mute.
// - cascade output shows previously held bits as new bits shift in.
// - strobe rising captures shift register into the holding latch.
// - after latching, addressed channel tap follows the data byte.
// - only the addressed channel changes; others keep their settings.
// - every channel is muted from reset until a frame addresses it.
// - on shared strobe rise each device latches its own 16 bits.
// - serial input shifts in on each serial clock rising edge.
// - shifting happens only while strobe is low for the whole frame.
// - unmatched selector leaves all channel settings unchanged.
`timescale 1ns/1ps
`default_nettype none
module serial_attenuator_control
    import atten_ctrl_pkg::*;
(
    input  wire logic       core_clk_in,
    input  wire logic       rstn_in,
    input  wire logic       sclk_in,
    input  wire logic       load_n_in,
    input  wire logic       data_in,
    output var  logic       cascade_out,
    output var  logic [6:0] ch1_tap_out,
    output var  logic [6:0] ch2_tap_out,
    output var  logic [6:0] ch3_tap_out,
    output var  logic [7:0] ch1_half_db_out,
    output var  logic [7:0] ch2_half_db_out,
    output var  logic [7:0] ch3_half_db_out,
    output var  logic       ch1_mute_out,
    output var  logic       ch2_mute_out,
    output var  logic       ch3_mute_out
);

    logic [2:0]   pins_s;
    logic         sclk_s;
    logic         load_n_s;
    logic         data_s;
    logic         sclk_rise;
    logic         load_rise;
    logic [1:0]   ch_idx;
    logic [7:0]   new_code;
    atten_state_t cur;
    atten_state_t next_cur;

    pin_sync pin_sync_inst (
        .core_clk_in (core_clk_in),
        .rstn_in     (rstn_in),
        .pins_in     ({load_n_in, sclk_in, data_in}),
        .pins_out    (pins_s)
    );

    assign load_n_s  = pins_s[2];
    assign sclk_s    = pins_s[1];
    assign data_s    = pins_s[0];
    assign sclk_rise = sclk_s & ~cur.sclk_prev;
    assign load_rise = load_n_s & ~cur.load_prev;
    assign ch_idx    = chan_index(cur.frame[SEL_MSB:SEL_LSB]);
    assign new_code  = cur.frame[CODE_MSB:CODE_LSB];

    always_comb begin
        next_cur           = cur;
        next_cur.sclk_prev = sclk_s;
        next_cur.load_prev = load_n_s;
        // oldest bit leaves first, so a frame passes on after 16 clocks
        next_cur.cascade   = cur.shift[FRAME_BITS-1];
        if (!load_n_s && sclk_rise) begin
            next_cur.shift = {cur.shift[FRAME_BITS-2:0], data_s};
        end
        case (cur.state)
            ST_IDLE: begin
                if (!load_n_s) begin
                    next_cur.state = ST_SHIFTING;
                end
            end
            ST_SHIFTING: begin
                if (load_rise) begin
                    next_cur.frame = cur.shift;
                    next_cur.state = ST_LATCHED;
                end
            end
            ST_LATCHED: begin
                // only a matched selector touches a channel
                if (ch_idx != CH_NONE) begin
                    next_cur.code[ch_idx]    = new_code;
                    next_cur.tap[ch_idx]     = tap_of(new_code);
                    next_cur.half_db[ch_idx] = half_db_of(new_code);
                    next_cur.mute[ch_idx]    = is_mute(new_code);
                end
                next_cur.state = load_n_s ? ST_IDLE : ST_SHIFTING;
            end
            default: begin
                next_cur.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            cur.sclk_prev <= 1'b0;
            cur.load_prev <= 1'b1;
            cur.state     <= ST_IDLE;
            cur.shift     <= SHIFT_RESET;
            cur.frame     <= SHIFT_RESET;
            cur.cascade   <= 1'b0;
            for (int i = 0; i < NUM_CH; i++) begin
                cur.code[i]    <= CODE_RESET;
                cur.tap[i]     <= TAP_MUTE;
                cur.half_db[i] <= HALF_DB_MUTE;
                cur.mute[i]    <= 1'b1;
            end
        end else begin
            cur <= next_cur;
        end
    end

    assign cascade_out     = cur.cascade;
    assign ch1_tap_out     = cur.tap[0];
    assign ch2_tap_out     = cur.tap[1];
    assign ch3_tap_out     = cur.tap[2];
    assign ch1_half_db_out = cur.half_db[0];
    assign ch2_half_db_out = cur.half_db[1];
    assign ch3_half_db_out = cur.half_db[2];
    assign ch1_mute_out    = cur.mute[0];
    assign ch2_mute_out    = cur.mute[1];
    assign ch3_mute_out    = cur.mute[2];

endmodule // serial_attenuator_control
`default_nettype wire

// ==== core/atten_ctrl_pkg.sv ====
// Purpose: shared constants, types and decode helpers of the attenuator control
// Assumes: frame is 16 bits, selector byte first, msb first
// Notes:   attenuation is reported in 0.5 dB units; mute reads as all ones
package atten_ctrl_pkg;

    localparam int unsigned FRAME_BITS  = 16;
    localparam int unsigned BYTE_BITS   = 8;
    localparam int unsigned NUM_CH      = 3;
    localparam int unsigned TAP_BITS    = 7;

    // selector byte codes
    localparam logic [7:0] CH1_SEL      = 8'h00;
    localparam logic [7:0] CH2_SEL      = 8'h01;
    localparam logic [7:0] CH3_SEL      = 8'h02;
    localparam logic [1:0] CH_NONE      = 2'h3;

    // attenuation code ranges
    localparam logic [7:0] CODE_STEP2_START = 8'h20;
    localparam logic [7:0] CODE_STEP3_START = 8'h40;
    localparam logic [7:0] CODE_MUTE_START  = 8'h4f;

    // attenuation in half-dB units at the start of each range
    localparam logic [7:0] HALF_DB_STEP2_BASE = 8'h20;
    localparam logic [7:0] HALF_DB_STEP3_BASE = 8'h60;
    localparam logic [7:0] HALF_DB_MUTE       = 8'hff;
    localparam logic [6:0] TAP_MUTE           = 7'h4f;

    // reset values
    localparam logic [7:0]  CODE_RESET  = 8'h4f;
    localparam logic [15:0] SHIFT_RESET = 16'h0000;
    // pin order {load_n, sclk, data}; strobe idles high, clock idles low
    localparam logic [2:0]  PIN_SYNC_RESET = 3'h4;

    // frame field positions
    localparam int unsigned SEL_MSB  = 15;
    localparam int unsigned SEL_LSB  = 8;
    localparam int unsigned CODE_MSB = 7;
    localparam int unsigned CODE_LSB = 0;

    typedef enum logic [1:0] {
        ST_IDLE     = 2'h0,
        ST_SHIFTING = 2'h1,
        ST_LATCHED  = 2'h3
    } frame_state_t;

    // channel index from selector byte, CH_NONE when unmatched
    function automatic logic [1:0] chan_index(input logic [7:0] sel);
        case (sel)
            CH1_SEL: chan_index = 2'h0;
            CH2_SEL: chan_index = 2'h1;
            CH3_SEL: chan_index = 2'h2;
            default: chan_index = CH_NONE;
        endcase
    endfunction

    function automatic logic is_mute(input logic [7:0] code);
        is_mute = (code >= CODE_MUTE_START);
    endfunction

    function automatic logic [6:0] tap_of(input logic [7:0] code);
        tap_of = is_mute(code) ? TAP_MUTE : code[6:0];
    endfunction

    function automatic logic [7:0] half_db_of(input logic [7:0] code);
        logic [7:0] d;
        d = 8'h00;
        if (is_mute(code)) begin
            half_db_of = HALF_DB_MUTE;
        end else if (code >= CODE_STEP3_START) begin
            d = code - CODE_STEP3_START;
            half_db_of = (d << 2) + HALF_DB_STEP3_BASE;
        end else if (code >= CODE_STEP2_START) begin
            d = code - CODE_STEP2_START;
            half_db_of = (d << 1) + HALF_DB_STEP2_BASE;
        end else begin
            half_db_of = code;
        end
    endfunction

    typedef struct packed {
        logic [2:0] meta;
        logic [2:0] sync;
    } pin_sync_state_t;

    typedef struct packed {
        logic                   sclk_prev;
        logic                   load_prev;
        frame_state_t           state;
        logic [15:0]            shift;
        logic [15:0]            frame;
        logic                   cascade;
        logic [2:0][7:0]        code;
        logic [2:0][6:0]        tap;
        logic [2:0][7:0]        half_db;
        logic [2:0]             mute;
    } atten_state_t;

endpackage

// ==== core/pin_sync.sv ====
// Purpose: two-flop synchroniser for the three serial control pins
// Assumes: pins are asynchronous to core_clk_in
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module pin_sync
    import atten_ctrl_pkg::*;
(
    input  wire logic       core_clk_in,
    input  wire logic       rstn_in,
    input  wire logic [2:0] pins_in,
    output var  logic [2:0] pins_out
);

    pin_sync_state_t cur;
    pin_sync_state_t next_cur;

    always_comb begin
        next_cur      = cur;
        next_cur.meta = pins_in;
        next_cur.sync = cur.meta;
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            // idle levels, so no false strobe or clock edge follows reset
            cur.meta <= PIN_SYNC_RESET;
            cur.sync <= PIN_SYNC_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    assign pins_out = cur.sync;

endmodule // pin_sync
`default_nettype wire

// ==== test/atten_host_model.sv ====
// Purpose: controller side of the three-wire serial link
// Assumes: paced from the core clock, 400 ns serial period
// Notes: data is inverted once the strobe is released
`timescale 1ns/1ps
`default_nettype none
module atten_host_model (
    input  wire logic clk_in,
    output var  logic sclk_out,
    output var  logic load_n_out,
    output var  logic data_out
);
    initial begin
        sclk_out = 1'b0;
        load_n_out = 1'b1;
        data_out = 1'b0;
    end
    // shifts v[n-1:0] msb first; hold keeps the strobe high throughout
    task automatic send(input logic [31:0] v, input int n, input logic hold);
        load_n_out <= hold;
        repeat (4) @(posedge clk_in);
        for (int i = n - 1; i >= 0; i--) begin
            data_out <= v[i];
            repeat (4) @(posedge clk_in);
            sclk_out <= 1'b1;
            repeat (4) @(posedge clk_in);
            sclk_out <= 1'b0;
        end
        repeat (4) @(posedge clk_in);
        load_n_out <= 1'b1;
        data_out <= ~data_out;
        repeat (8) @(posedge clk_in);
    endtask
endmodule // atten_host_model
`default_nettype wire

// ==== test/serial_attenuator_control_properties.sv ====
// Purpose: port checks of the attenuator control
// Assumes: serial pins far slower than the core clock
// Notes: hi counts strobe-high cycles, up counts since a clock rise
`timescale 1ns/1ps
`default_nettype none
module atten_ctrl_checker (
    input wire logic       core_clk_in,
    input wire logic       rstn_in,
    input wire logic       sclk_in,
    input wire logic       load_n_in,
    input wire logic       cascade_out,
    input wire logic [6:0] ch1_tap_out,
    input wire logic [6:0] ch2_tap_out,
    input wire logic [6:0] ch3_tap_out,
    input wire logic [7:0] ch1_half_db_out,
    input wire logic [7:0] ch2_half_db_out,
    input wire logic [7:0] ch3_half_db_out,
    input wire logic       ch1_mute_out,
    input wire logic       ch2_mute_out,
    input wire logic       ch3_mute_out
);
    logic [3:0] hi;
    logic [3:0] up;
    logic       prev;
    always_ff @(posedge core_clk_in) begin
        prev <= sclk_in;
        if (!rstn_in) begin
            hi <= 4'h0;
            up <= 4'hf;
        end else begin
            hi <= !load_n_in ? 4'h0 : (hi == 4'hf ? hi : hi + 4'h1);
            up <= (sclk_in && !prev) ? 4'h0 : (up == 4'hf ? up : up + 4'h1);
        end
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    chk_reset_mute: assert property (disable iff (1'b0) !rstn_in
        |=> ch1_mute_out && ch2_mute_out && ch3_mute_out)
        else $error("no mute after reset");
    chk_hold_still: assert property (hi >= 4'ha
        |=> $stable({ch1_tap_out, ch2_tap_out, ch3_tap_out})) else $error("drift");
    chk_update_time: assert property ($changed(ch1_tap_out)
        |-> hi inside {[2:9]}) else $error("tap change off strobe rise");
    chk_casc_idle: assert property (hi >= 4'h4
        |=> $stable(cascade_out)) else $error("shift with strobe high");
    chk_casc_edge: assert property ($changed(cascade_out)
        |-> up inside {[1:8]}) else $error("cascade moved without clock");
    chk_mute_out: assert property (ch1_mute_out
        |-> ch1_tap_out == 7'h4f && ch1_half_db_out == 8'hff) else $error("mute");
    chk_fine_db: assert property (!ch2_mute_out && ch2_tap_out < 7'h20
        |-> ch2_half_db_out == {1'b0, ch2_tap_out}) else $error("fine step");
    chk_coarse_db: assert property (ch3_tap_out inside {[7'h40:7'h4e]}
        |-> ch3_half_db_out == {ch3_tap_out[5:0], 2'b00} + 8'h60) else $error("2dB");
    cover property ($fell(ch1_mute_out));
    cover property ($changed(cascade_out));
    cover property ($changed(ch3_tap_out));
endmodule // atten_ctrl_checker
bind serial_attenuator_control atten_ctrl_checker atten_ctrl_checker_inst (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .sclk_in(sclk_in),
    .load_n_in(load_n_in), .cascade_out(cascade_out),
    .ch1_tap_out(ch1_tap_out), .ch2_tap_out(ch2_tap_out),
    .ch3_tap_out(ch3_tap_out), .ch1_half_db_out(ch1_half_db_out),
    .ch2_half_db_out(ch2_half_db_out), .ch3_half_db_out(ch3_half_db_out),
    .ch1_mute_out(ch1_mute_out), .ch2_mute_out(ch2_mute_out),
    .ch3_mute_out(ch3_mute_out));
`default_nettype wire

// ==== test/serial_attenuator_control_tb_top.sv ====
// Purpose: self-checking bench of the attenuator serial control
// Assumes: host model paces the serial clock
// Notes: expected words are {tap, half dB}; mute when half dB is ff
`timescale 1ns/1ps
`default_nettype none
module serial_attenuator_control_tb_top;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic       sclk, load_n, sdata, casc, m1, m2, m3;
    logic [6:0] t1, t2, t3;
    logic [7:0] d1, d2, d3;
    int         failures = 0;
    int         total_checks = 0;
    always #25 clk = ~clk;
    atten_host_model atten_host_model_inst (.clk_in(clk), .sclk_out(sclk),
        .load_n_out(load_n), .data_out(sdata));
    serial_attenuator_control serial_attenuator_control_inst (
        .core_clk_in(clk), .rstn_in(rstn), .sclk_in(sclk),
        .load_n_in(load_n), .data_in(sdata), .cascade_out(casc),
        .ch1_tap_out(t1), .ch2_tap_out(t2), .ch3_tap_out(t3),
        .ch1_half_db_out(d1), .ch2_half_db_out(d2), .ch3_half_db_out(d3),
        .ch1_mute_out(m1), .ch2_mute_out(m2), .ch3_mute_out(m3));
    task automatic go(input logic [31:0] v, input int n, input logic hold);
        atten_host_model_inst.send(v, n, hold);
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chan(input logic [6:0] t, input logic [7:0] d,
                        input logic m, input logic [15:0] e);
        cmp({t, d, m}, {e[14:0], e[7:0] == 8'hff});
    endtask
    task automatic t_reset();
        chan(t1, d1, m1, 16'h4fff);
        chan(t2, d2, m2, 16'h4fff);
        chan(t3, d3, m3, 16'h4fff);
        cmp(casc, 0);
        $display("reset test done");
    endtask
    task automatic t_codes();
        logic [23:0] tab [10] = '{24'h000000, 24'h1f1f1f, 24'h202020,
            24'h25252a, 24'h3f3f5e, 24'h404060, 24'h4f4fff, 24'hff4fff,
            24'h454574, 24'h4e4e98};
        foreach (tab[i]) begin
            go({24'h0, tab[i][23:16]}, 16, 1'b0);
            chan(t1, d1, m1, tab[i][15:0]);
            chan(t2, d2, m2, 16'h4fff);
        end
        $display("codes test done");
    endtask
    task automatic t_chans();
        go(32'h0110, 16, 1'b0);
        go(32'h0245, 16, 1'b0);
        go(32'h0300, 16, 1'b0);
        go(32'h0000, 16, 1'b1);
        chan(t1, d1, m1, 16'h4e98);
        chan(t2, d2, m2, 16'h1010);
        chan(t3, d3, m3, 16'h4574);
        $display("channel test done");
    endtask
    task automatic t_chain();
        logic [31:0] cap;
        fork
            go(32'h0201_0111, 32, 1'b0);
            repeat (32) @(posedge sclk) cap = {cap[30:0], casc};
        join
        cmp(cap, 32'h0300_0201);
        chan(t2, d2, m2, 16'h1111);
        chan(t3, d3, m3, 16'h4574);
        $display("chain test done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_codes();
        t_chans();
        t_chain();
        report_and_stop();
    end
    initial begin
        repeat (10000) @(posedge clk);
        failures++;
        report_and_stop();
    end
endmodule // serial_attenuator_control_tb_top
`default_nettype wire
